// >>> inc/prl_pkg.sv
/*
  prl_pkg: constants, class encodings and the stream beat carrier for the
  per-port rate limiter.
  assumes: included before the limiter module; no clock or reset of its own.
*/
`default_nettype none
package prl_pkg;

  // port indexing and rate field widths
  localparam int unsigned PORT_W    = 4;
  localparam int unsigned RATE_W    = 18;    // holds up to 256000 kbps
  localparam int unsigned BUCKET_W  = 24;    // signed credit in bits

  // accepted nonzero rate range in kbps
  localparam logic [RATE_W-1:0] RATE_MIN_KBPS  = 18'h00064;  // 100
  localparam logic [RATE_W-1:0] RATE_FAST_MAX  = 18'h19000;  // 102400
  localparam logic [RATE_W-1:0] RATE_GIGA_MAX  = 18'h3e800;  // 256000
  localparam logic [RATE_W-1:0] RATE_RESET     = 18'h00000;  // zero = unlimited

  // credit refill: every refill period a port earns its rate in bits,
  // since kbps times one millisecond equals bits
  localparam int unsigned CLK_MHZ      = 250;
  localparam int unsigned REFILL_US    = 1000;
  localparam int unsigned REFILL_CYC   = REFILL_US * CLK_MHZ;

  // bits charged per accepted stream beat (one byte per beat)
  localparam int unsigned BEAT_BYTES   = 1;
  localparam logic [BUCKET_W-1:0] BEAT_BITS = BUCKET_W'(BEAT_BYTES * 8);

  // ingress frame class selector
  typedef enum logic [1:0] {
    PRL_CLS_ALL      = 2'b00,
    PRL_CLS_BMF      = 2'b01,   // broadcast, multicast, flooded unicast
    PRL_CLS_BM       = 2'b10,   // broadcast, multicast
    PRL_CLS_BCAST    = 2'b11
  } prl_class_type;

  // one stream beat; frame kind flags are valid on the first beat
  typedef struct packed {
    logic [7:0]        data;
    logic              sop;
    logic              eop;
    logic [PORT_W-1:0] port;
    logic              bcast;
    logic              mcast;
    logic              flood;
  } prl_beat_type;

  localparam int unsigned BEAT_W = $bits(prl_beat_type);

endpackage
`default_nettype wire

// >>> verilog/prl_rate_limiter.sv
/*
  prl_rate_limiter: per-port ingress and egress bandwidth limiter with a
  two-entry buffer on each outgoing stream.
  assumes: one clock, frames arrive whole (no interleaving) on each stream,
  configuration writer and stream partners run on ref_clk_i.
*/
// Function
// (RULE1) every port owns separate ingress and egress rate limits
// (RULE2) ingress class per port: all, bcast/mcast/flood, bcast/mcast, bcast only
// (RULE3) egress meters every frame regardless of kind
// (RULE4) nonzero fast-port rates are held between 100 and 102400 kbps
// (RULE5) gigabit ports allow nonzero rates up to 256000 kbps
// (RULE6) zero rate means no limit; both rates reset to zero
// (RULE7) ingress metering decides per received packet against the rate
// (RULE8) unclassed frames bypass; classed frames over the rate are dropped
`timescale 1ns/1ps
`default_nettype none

module prl_skid_buf #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  logic [WIDTH-1:0] mem_reg [2];
  logic             wr_ptr_reg;
  logic             rd_ptr_reg;
  logic [1:0]       count_reg;
  logic             push;
  logic             pop;

  // full and empty come straight from the fill count
  assign in_ready_o  = (count_reg != 2'h2);
  assign out_valid_o = (count_reg != 2'h0);
  assign out_data_o  = mem_reg[rd_ptr_reg];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // storage
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // pointers and count
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      count_reg <= 2'(count_reg + {1'b0, push} - {1'b0, pop});
    end
  end
endmodule // prl_skid_buf

module prl_rate_limiter
  import prl_pkg::*;
#(
  parameter int unsigned      NUM_PORTS  = 10,
  parameter logic [15:0]      GIGA_MASK  = 16'h0300,   // ports 8 and 9
  parameter int unsigned      REFILL_CYCLES = REFILL_CYC
) (
  input  wire logic                ref_clk_i,
  input  wire logic                rst_i,
  // configuration write, one port at a time
  input  wire logic                cfg_wr_i,
  input  wire logic [PORT_W-1:0]   cfg_port_i,
  input  wire logic [RATE_W-1:0]   cfg_ing_rate_i,
  input  wire logic [RATE_W-1:0]   cfg_eg_rate_i,
  input  wire prl_class_type       cfg_class_i,
  // ingress: from port MACs toward the fabric
  input  wire logic                ing_valid_i,
  output logic                     ing_ready_o,
  input  wire prl_beat_type        ing_beat_i,
  output logic                     ing_valid_o,
  input  wire logic                ing_ready_i,
  output prl_beat_type             ing_beat_o,
  output logic                     ing_drop_o,
  // egress: from the fabric toward port MACs
  input  wire logic                eg_valid_i,
  output logic                     eg_ready_o,
  input  wire prl_beat_type        eg_beat_i,
  output logic                     eg_valid_o,
  input  wire logic                eg_ready_i,
  output prl_beat_type             eg_beat_o
);

  logic [RATE_W-1:0]   ing_rate_reg [NUM_PORTS];
  logic [RATE_W-1:0]   eg_rate_reg  [NUM_PORTS];
  prl_class_type       class_reg    [NUM_PORTS];
  logic [NUM_PORTS-1:0] ing_neg;
  logic [NUM_PORTS-1:0] eg_neg;
  logic [31:0]         tick_cnt_reg;
  logic                tick;
  logic                ing_drop_reg;
  logic                ing_meter_reg;
  logic                ing_in_frame_reg;
  logic                ing_buf_ready;
  logic                ing_take;
  logic                ing_cls_hit;
  logic                ing_meter_now;
  logic                ing_drop_now;
  logic                ing_charge;
  logic                eg_buf_ready;
  logic                eg_hold;
  logic                eg_take;
  logic [BEAT_W-1:0]   ing_out_raw;
  logic [BEAT_W-1:0]   eg_out_raw;
  prl_class_type       ing_cls;

  // keep a nonzero rate inside the accepted range for this port's speed
  function automatic logic [RATE_W-1:0] clamp_rate(input logic [RATE_W-1:0] r,
                                                   input logic giga);
    logic [RATE_W-1:0] hi;
    hi = giga ? RATE_GIGA_MAX : RATE_FAST_MAX;   // RULE5
    if (r == RATE_RESET) begin
      clamp_rate = RATE_RESET;                    // RULE6
    end else if (r < RATE_MIN_KBPS) begin
      clamp_rate = RATE_MIN_KBPS;                 // RULE4
    end else if (r > hi) begin
      clamp_rate = hi;                            // RULE4
    end else begin
      clamp_rate = r;
    end
  endfunction

  // refill tick once per refill period
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt_reg <= 32'h0;
    end else if (tick) begin
      tick_cnt_reg <= 32'h0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
    end
  end
  assign tick = (tick_cnt_reg == 32'(REFILL_CYCLES - 1));

  // ingress frame classification and drop decision at the first beat
  assign ing_cls = class_reg[ing_beat_i.port];
  always_comb begin
    case (ing_cls)                                                   // RULE2
      PRL_CLS_ALL:   ing_cls_hit = 1'b1;
      PRL_CLS_BMF:   ing_cls_hit = ing_beat_i.bcast | ing_beat_i.mcast | ing_beat_i.flood;
      PRL_CLS_BM:    ing_cls_hit = ing_beat_i.bcast | ing_beat_i.mcast;
      PRL_CLS_BCAST: ing_cls_hit = ing_beat_i.bcast;
      default:       ing_cls_hit = 1'b0;
    endcase
  end
  assign ing_meter_now = ing_cls_hit & (ing_rate_reg[ing_beat_i.port] != RATE_RESET); // RULE8
  assign ing_drop_now  = ing_meter_now & ing_neg[ing_beat_i.port];                  // RULE7
  assign ing_take      = ing_valid_i & ing_ready_o;

  // dropped beats are swallowed at full speed; kept beats wait for the buffer
  assign ing_ready_o = (ing_beat_i.sop | ~ing_in_frame_reg) ?
                       (ing_drop_now | ing_buf_ready) :
                       (ing_drop_reg | ing_buf_ready);
  logic ing_first;
  logic ing_drop_cur;
  assign ing_first    = ing_beat_i.sop | ~ing_in_frame_reg;
  assign ing_drop_cur = ing_first ? ing_drop_now : ing_drop_reg;     // RULE8
  assign ing_charge   = ing_take & ~ing_drop_cur &
                        (ing_first ? ing_meter_now : ing_meter_reg);
  assign ing_drop_o   = ing_drop_reg & ing_in_frame_reg;

  // per-frame ingress state held from first beat to last
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ing_drop_reg     <= 1'b0;
      ing_meter_reg    <= 1'b0;
      ing_in_frame_reg <= 1'b0;
    end else if (ing_take) begin
      ing_in_frame_reg <= ~ing_beat_i.eop;
      if (ing_first) begin
        ing_drop_reg  <= ing_drop_now;
        ing_meter_reg <= ing_meter_now;
      end
    end
  end

  prl_skid_buf #(.WIDTH(BEAT_W)) u_ing_buf (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (ing_valid_i & ~ing_drop_cur),
    .in_ready_o  (ing_buf_ready),
    .in_data_i   (ing_beat_i),
    .out_valid_o (ing_valid_o),
    .out_ready_i (ing_ready_i),
    .out_data_o  (ing_out_raw)
  );
  assign ing_beat_o = prl_beat_type'(ing_out_raw);

  // egress holds a new frame until its port has credit, every kind alike
  assign eg_hold    = eg_beat_i.sop & eg_neg[eg_beat_i.port] &
                      (eg_rate_reg[eg_beat_i.port] != RATE_RESET);   // RULE3
  assign eg_ready_o = eg_buf_ready & ~eg_hold;
  assign eg_take    = eg_valid_i & eg_ready_o;

  prl_skid_buf #(.WIDTH(BEAT_W)) u_eg_buf (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (eg_valid_i & ~eg_hold),
    .in_ready_o  (eg_buf_ready),
    .in_data_i   (eg_beat_i),
    .out_valid_o (eg_valid_o),
    .out_ready_i (eg_ready_i),
    .out_data_o  (eg_out_raw)
  );
  assign eg_beat_o = prl_beat_type'(eg_out_raw);

  // per-port configuration and credit buckets
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    logic signed [BUCKET_W-1:0] ing_bkt_reg;
    logic signed [BUCKET_W-1:0] eg_bkt_reg;
    logic signed [BUCKET_W-1:0] ing_bkt_next;
    logic signed [BUCKET_W-1:0] eg_bkt_next;
    logic signed [BUCKET_W-1:0] ing_cap;
    logic signed [BUCKET_W-1:0] eg_cap;
    logic                       ing_sel;
    logic                       eg_sel;

    assign ing_cap = BUCKET_W'(ing_rate_reg[p]);
    assign eg_cap  = BUCKET_W'(eg_rate_reg[p]);
    assign ing_sel = ing_charge & (ing_beat_i.port == PORT_W'(p));
    assign eg_sel  = eg_take & (eg_beat_i.port == PORT_W'(p));

    // configuration, reset to unlimited
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
        ing_rate_reg[p] <= RATE_RESET;                              // RULE6
        eg_rate_reg[p]  <= RATE_RESET;                              // RULE6
        class_reg[p]    <= PRL_CLS_ALL;
      end else if (cfg_wr_i && cfg_port_i == PORT_W'(p)) begin
        ing_rate_reg[p] <= clamp_rate(cfg_ing_rate_i, GIGA_MASK[p]); // RULE1
        eg_rate_reg[p]  <= clamp_rate(cfg_eg_rate_i, GIGA_MASK[p]);  // RULE1
        class_reg[p]    <= cfg_class_i;
      end
    end

    // refill by rate each tick, charge per beat, cap at one period of credit
    always_comb begin
      ing_bkt_next = ing_bkt_reg;
      eg_bkt_next  = eg_bkt_reg;
      if (tick) begin
        ing_bkt_next = ing_bkt_next + ing_cap;
        eg_bkt_next  = eg_bkt_next + eg_cap;
      end
      if (ing_sel) begin
        ing_bkt_next = ing_bkt_next - BEAT_BITS;                    // RULE7
      end
      if (eg_sel && eg_cap != '0) begin
        eg_bkt_next = eg_bkt_next - BEAT_BITS;                      // RULE3
      end
      if (ing_bkt_next > ing_cap) begin
        ing_bkt_next = ing_cap;
      end
      if (eg_bkt_next > eg_cap) begin
        eg_bkt_next = eg_cap;
      end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
        ing_bkt_reg <= '0;
        eg_bkt_reg  <= '0;
      end else begin
        ing_bkt_reg <= ing_bkt_next;
        eg_bkt_reg  <= eg_bkt_next;
      end
    end

    assign ing_neg[p] = ing_bkt_reg[BUCKET_W-1];
    assign eg_neg[p]  = eg_bkt_reg[BUCKET_W-1];
  end

endmodule // prl_rate_limiter
`default_nettype wire

// >>> tb/prl_rate_limiter_monitor.sv
/*
  prl_rate_limiter_monitor: stream hold, drop and pass-through checks.
  assumes: bound to prl_rate_limiter, one clock, async active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module prl_rate_limiter_monitor
  import prl_pkg::*;
(
  input wire logic         ref_clk_i,
  input wire logic         rst_i,
  input wire logic         ing_valid_i,
  input wire logic         ing_ready_o,
  input wire prl_beat_type ing_beat_i,
  input wire logic         ing_valid_o,
  input wire logic         ing_ready_i,
  input wire prl_beat_type ing_beat_o,
  input wire logic         ing_drop_o,
  input wire logic         eg_valid_i,
  input wire logic         eg_ready_o,
  input wire prl_beat_type eg_beat_i,
  input wire logic         eg_valid_o,
  input wire logic         eg_ready_i,
  input wire prl_beat_type eg_beat_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // outputs start empty, buffers and rates cleared
  AST_RST_EMPTY: assert property ($fell(rst_i) |-> !ing_valid_o && !eg_valid_o)
    else $error("output valid right after reset");
  // a stalled beat stays put
  AST_ING_HOLD: assert property (ing_valid_o && !ing_ready_i |=> ing_valid_o && $stable(ing_beat_o))
    else $error("ingress beat lost under stall");
  AST_EG_HOLD: assert property (eg_valid_o && !eg_ready_i |=> eg_valid_o && $stable(eg_beat_o))
    else $error("egress beat lost under stall");
  // a dropped frame is swallowed at full speed until its end
  AST_DROP_RDY: assert property (ing_drop_o |-> ing_ready_o)
    else $error("drop without ready");
  AST_DROP_SOP: assert property ($rose(ing_drop_o) |-> $past(ing_valid_i) && $past(ing_beat_i.sop))
    else $error("drop began off a frame start");
  AST_DROP_KEEP: assert property (ing_drop_o && ing_valid_i && !ing_beat_i.eop |=> ing_drop_o)
    else $error("drop ended mid frame");
  AST_DROP_END: assert property (ing_drop_o && ing_valid_i && ing_beat_i.eop |=> !ing_drop_o)
    else $error("drop outlived frame end");
  // kept beats reach an empty buffer one cycle later
  AST_ING_NEXT: assert property (ing_valid_i && ing_ready_o && !ing_beat_i.sop && !ing_drop_o
    && !ing_valid_o |=> ing_valid_o)
    else $error("kept ingress beat missing");
  AST_EG_NEXT: assert property (eg_valid_i && eg_ready_o && !eg_valid_o
    |=> eg_valid_o && eg_beat_o == $past(eg_beat_i))
    else $error("egress beat missing or altered");
  // main scenarios reached
  COV_DROP: cover property ($rose(ing_drop_o));
  COV_EG_HELD: cover property (eg_valid_i && !eg_ready_o && !eg_valid_o);
  COV_ING_STALL: cover property (ing_valid_o && !ing_ready_i);
endmodule // prl_rate_limiter_monitor

bind prl_rate_limiter prl_rate_limiter_monitor mon_u (.ref_clk_i, .rst_i, .ing_valid_i,
  .ing_ready_o, .ing_beat_i, .ing_valid_o, .ing_ready_i, .ing_beat_o, .ing_drop_o,
  .eg_valid_i, .eg_ready_o, .eg_beat_i, .eg_valid_o, .eg_ready_i, .eg_beat_o);
`default_nettype wire

// >>> tb/prl_sink.sv
/*
  prl_sink: far-side receiver of one limiter stream; counts beats taken.
  assumes: same clock and reset as the limiter.
*/
`timescale 1ns/1ps
`default_nettype none
module prl_sink (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        valid_i,
  input  wire logic        stall_i,
  input  wire logic        slow_i,
  input  wire logic [7:0]  data_i,
  output logic             ready_o,
  output logic      [15:0] count_o,
  output logic      [7:0]  last_o
);
  logic phase_reg;
  // ready unless stalled; every other cycle when slow
  assign ready_o = !stall_i && (!slow_i || phase_reg);
  // phase for the slow receiver
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) phase_reg <= 1'b0;
    else phase_reg <= !phase_reg;
  end
  // beats taken
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) count_o <= 16'h0000;
    else if (valid_i && ready_o) count_o <= count_o + 16'h0001;
  end
  // data byte of the last beat taken
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) last_o <= 8'h00;
    else if (valid_i && ready_o) last_o <= data_i;
  end
endmodule // prl_sink
`default_nettype wire

// >>> tb/tb_port_rate_limiter.sv
/*
  tb_port_rate_limiter: class table, buffer stall, refill and egress hold tests.
  assumes: prl_pkg, the limiter, prl_sink and the monitor are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_port_rate_limiter;
  import prl_pkg::*;
  typedef struct packed {
    logic [3:0] p; prl_class_type c; logic [2:0] k; logic [17:0] r; logic keep;
  } prl_row_type;
  logic              ref_clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              cfg_wr = 1'b0;
  logic [PORT_W-1:0] cfg_port = '0;
  logic [RATE_W-1:0] cfg_ing = '0;
  logic [RATE_W-1:0] cfg_eg = '0;
  prl_class_type     cfg_cls = PRL_CLS_ALL;
  logic              ing_v = 1'b0, eg_v = 1'b0, ing_stall = 1'b0;
  logic              ing_rdy, eg_rdy, ing_vo, eg_vo, ing_ri, eg_ri;
  prl_beat_type      bt = '0;
  logic [15:0]       ing_cnt, eg_cnt, base;
  logic [15:0]       n_drop = '0, drop_base;
  logic [7:0]        ing_last, eg_last;
  logic              ing_drop;
  prl_beat_type      ing_bo, eg_bo;
  int                n_errors = 0, samples_checked = 0, cyc = 0;
  // port, class, {bcast,mcast,flood}, ingress rate, second frame kept
  prl_row_type rows [8] = '{
    '{4'h1, PRL_CLS_ALL, 3'b000, 18'h00001, 1'b0}, '{4'h2, PRL_CLS_BMF, 3'b001, 18'h00001, 1'b0},
    '{4'h3, PRL_CLS_BMF, 3'b000, 18'h00001, 1'b1}, '{4'h4, PRL_CLS_BM, 3'b010, 18'h00001, 1'b0},
    '{4'h5, PRL_CLS_BM, 3'b001, 18'h00001, 1'b1}, '{4'h6, PRL_CLS_BCAST, 3'b100, 18'h00001, 1'b0},
    '{4'h7, PRL_CLS_BCAST, 3'b010, 18'h00001, 1'b1}, '{4'h8, PRL_CLS_ALL, 3'b000, 18'h00000, 1'b1}};

  prl_rate_limiter #(.REFILL_CYCLES(2000)) dut_u (.ref_clk_i, .rst_i, .cfg_wr_i(cfg_wr),
    .cfg_port_i(cfg_port), .cfg_ing_rate_i(cfg_ing), .cfg_eg_rate_i(cfg_eg),
    .cfg_class_i(cfg_cls), .ing_valid_i(ing_v), .ing_ready_o(ing_rdy), .ing_beat_i(bt),
    .ing_valid_o(ing_vo), .ing_ready_i(ing_ri), .ing_beat_o(ing_bo), .ing_drop_o(ing_drop),
    .eg_valid_i(eg_v), .eg_ready_o(eg_rdy), .eg_beat_i(bt), .eg_valid_o(eg_vo),
    .eg_ready_i(eg_ri), .eg_beat_o(eg_bo));
  prl_sink ing_sink_u (.ref_clk_i, .rst_i, .valid_i(ing_vo), .stall_i(ing_stall),
    .slow_i(1'b0), .data_i(ing_bo.data), .ready_o(ing_ri), .count_o(ing_cnt),
    .last_o(ing_last));
  prl_sink eg_sink_u (.ref_clk_i, .rst_i, .valid_i(eg_vo), .stall_i(1'b0),
    .slow_i(1'b1), .data_i(eg_bo.data), .ready_o(eg_ri), .count_o(eg_cnt),
    .last_o(eg_last));

  // cycles in which the rest of a dropped frame is swallowed
  always @(negedge ref_clk_i) begin
    if (ing_drop) n_drop++;
  end

  // 250 MHz clock
  always #2 ref_clk_i = ~ref_clk_i;

  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // one-cycle configuration write
  task automatic cfg(input logic [3:0] p, input logic [17:0] ir, input logic [17:0] er,
                     input prl_class_type c);
    cfg_wr = 1'b1;
    cfg_port = p;
    cfg_ing = ir;
    cfg_eg = er;
    cfg_cls = c;
    @(posedge ref_clk_i); #1;
    cfg_wr = 1'b0;
  endtask

  // two-beat frame; ready is looked at mid-cycle, taken at the next edge
  task automatic send(input logic [3:0] p, input logic [2:0] k, input bit eg);
    for (int i = 0; i < 2; i++) begin
      bt = '{data: 8'(i), sop: i == 0, eop: i == 1, port: p, bcast: k[2], mcast: k[1],
             flood: k[0]};
      ing_v = !eg;
      eg_v = eg;
      @(negedge ref_clk_i);
      while (!(eg ? eg_rdy : ing_rdy)) @(negedge ref_clk_i);
      @(posedge ref_clk_i); #1;
    end
    ing_v = 1'b0;
    eg_v = 1'b0;
    @(posedge ref_clk_i);
    #1;
  endtask

  // wait until both output buffers have drained
  task automatic idle;
    repeat (2) @(posedge ref_clk_i);
    #1;
    while (ing_vo || eg_vo) begin
      @(posedge ref_clk_i);
      #1;
    end
  endtask

  // cycle ceiling against hangs
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 8000) begin
      n_errors++;
      final_report();
    end
  end

  initial begin
    repeat (8) @(posedge ref_clk_i); #1;
    chk(16'({ing_vo, eg_vo, ing_rdy, eg_rdy}), 16'h0003);
    rst_i = 1'b0;
    @(posedge ref_clk_i); #1;
    send(4'h0, 3'b000, 1'b1);
    send(4'h0, 3'b000, 1'b0);
    idle();
    chk(eg_cnt, 16'h0002);
    chk(ing_cnt, 16'h0002);
    chk(16'(ing_last), 16'h0001);
    chk(16'(eg_last), 16'h0001);
    // class table: first metered frame passes, second is dropped
    foreach (rows[i]) begin
      base = ing_cnt;
      drop_base = n_drop;
      cfg(rows[i].p, rows[i].r, 18'h00000, rows[i].c);
      send(rows[i].p, rows[i].k, 1'b0);
      send(rows[i].p, rows[i].k, 1'b0);
      idle();
      chk(ing_cnt - base, rows[i].keep ? 16'h0004 : 16'h0002);
      chk(n_drop - drop_base, rows[i].keep ? 16'h0000 : 16'h0001);
    end
    // stalled receiver: buffer fills after two beats, nothing lost
    base = ing_cnt;
    ing_stall = 1'b1;
    send(4'h0, 3'b000, 1'b0);
    @(negedge ref_clk_i);
    chk(16'(ing_rdy), 16'h0000);
    @(posedge ref_clk_i);
    #1;
    ing_stall = 1'b0;
    idle();
    chk(ing_cnt - base, 16'h0002);
    // after a refill the raised minimum rate lets port 1 through again
    while (cyc < 2030) @(posedge ref_clk_i);
    #1;
    base = ing_cnt;
    send(4'h1, 3'b000, 1'b0);
    idle();
    chk(ing_cnt - base, 16'h0002);
    // egress meters unicast even with a broadcast-only ingress class
    cfg(4'h9, 18'h00000, 18'h00001, PRL_CLS_BCAST);
    base = eg_cnt;
    send(4'h9, 3'b000, 1'b1);
    @(posedge ref_clk_i); #1;
    bt = '{data: 8'h00, sop: 1'b1, eop: 1'b0, port: 4'h9, bcast: 1'b0, mcast: 1'b0,
           flood: 1'b0};
    eg_v = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    chk(16'(eg_rdy), 16'h0000);
    @(posedge ref_clk_i);
    #1;
    send(4'h9, 3'b000, 1'b1);
    idle();
    chk(eg_cnt - base, 16'h0004);
    final_report();
  end
endmodule // tb_port_rate_limiter
`default_nettype wire
